// file: watchdog_reset_flags.sv
// Watchdog timer with timed configuration unlock and reset-cause flags.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module watchdog_reset_flags #(
  parameter int unsigned BASE_CYCLES = wd_pkg::BASE_PERIOD,
  parameter int unsigned CNT_W = 20
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata_q,
  // Processor core.
  input wire logic wd_restart,
  input wire logic global_irq_enable,
  input wire logic irq_taken,
  output logic wd_irq_q,
  // Reset sources and watchdog reset out.
  input wire logic brownout_reset_evt,
  input wire logic pin_reset_evt,
  output logic wd_reset_q,
  // Oscillator and fuse pins.
  input wire logic wd_osc,
  input wire logic wd_always_on_fuse,
  // Reference power control.
  input wire logic brownout_detect_on,
  input wire logic comparator_bandgap_select,
  input wire logic adc_enable,
  output logic bandgap_power_q
);

  if (BASE_CYCLES < 2 || CNT_W > 31 ||
      (BASE_CYCLES << 9) > (32'd1 << CNT_W))
  begin : g_bad_params
    $error("watchdog counter too narrow for the base period");
  end

  // Last counter value of the selected period.
  function automatic logic [CNT_W-1:0] last_count(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > wd_pkg::PS_LAST_VALID) ? wd_pkg::PS_FALLBACK : sel;
    last_count = CNT_W'((BASE_CYCLES << s) - 1);
  endfunction : last_count

  // One strobe qualified by one register address.
  function automatic logic addr_hit(input logic strobe,
                                    input logic [7:0] a,
                                    input logic [7:0] target);
    addr_hit = strobe && (a == target);
  endfunction : addr_hit

  // A new cause wins over a clearing write in the same cycle.
  function automatic logic next_flag(input logic cause, input logic flag,
                                     input logic clear);
    next_flag = cause | (flag & ~clear);
  endfunction : next_flag

  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic fuse_s1_q;
  logic fuse_s2_q;
  logic level2_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic irq_flag_q;
  logic irq_flag_d;
  logic irq_en_q;
  logic irq_en_d;
  logic en_q;
  logic en_d;
  logic [3:0] ps_q;
  logic [3:0] ps_d;
  logic [2:0] win_q;
  logic [2:0] win_d;
  logic por_q;
  logic pin_q;
  logic bor_q;
  logic wdr_q;
  logic [7:0] rdata_d;
  logic por_d;
  logic pin_d;
  logic bor_d;
  logic wdr_d;
  logic wd_reset_d;
  logic wd_irq_d;
  logic bandgap_d;
  logic [7:0] rc_word;
  logic [7:0] ct_word;

  wire osc_tick = osc_s2_q & ~osc_s3_q;
  wire wr_rc = addr_hit(wr_en, addr, wd_pkg::ADDR_RESET_CAUSE);
  wire wr_ct = addr_hit(wr_en, addr, wd_pkg::ADDR_WD_CONTROL);
  wire rd_rc = addr_hit(rd_en, addr, wd_pkg::ADDR_RESET_CAUSE);
  wire rd_ct = addr_hit(rd_en, addr, wd_pkg::ADDR_WD_CONTROL);
  wire w_ce = wdata[wd_pkg::CT_CHANGE_EN];
  wire w_en = wdata[wd_pkg::CT_ENABLE];
  wire [3:0] w_ps = {wdata[wd_pkg::CT_PS_HI],
                     wdata[wd_pkg::CT_PS_LO_TOP:0]};
  wire win_open = (win_q != 3'h0);
  wire chip_rst = brownout_reset_evt | pin_reset_evt | wd_reset_q;
  // Level 1 enable is held up by the watchdog reset flag.
  wire en_eff = level2_q | en_q | wdr_q;
  wire running = en_eff | irq_en_q;
  wire timeout = running && osc_tick && (cnt_q == last_count(ps_q));
  wire guarded_ok = win_open & ~w_ce;
  wire ps_ok = ~level2_q | guarded_ok;
  wire flag_clr = wr_rc & ~wdata[wd_pkg::RC_WATCHDOG];

  // Oscillator passes two flip-flops before use, the fuse three.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= wd_osc;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
      level2_q <= 1'b0;
    end
    else
    begin
      fuse_s1_q <= wd_always_on_fuse;
      fuse_s2_q <= fuse_s1_q;
      level2_q <= fuse_s2_q;
    end
  end

  // Any clear source wins over a tick, so a restart never lands late.
  always_comb
  begin
    if (chip_rst || wd_restart || !running || timeout)
      cnt_d = '0;
    else if (osc_tick)
      cnt_d = cnt_q + CNT_W'(1);
    else
      cnt_d = cnt_q;
  end

  always_comb
  begin
    if (chip_rst)
      en_d = 1'b0;
    else if (wr_ct && w_en)
      en_d = 1'b1;
    else if (wr_ct && guarded_ok)
      en_d = 1'b0;
    else
      en_d = en_q;
  end

  always_comb
  begin
    if (chip_rst)
      ps_d = wd_pkg::PS_RESET;
    else if (wr_ct && ps_ok)
      ps_d = w_ps;
    else
      ps_d = ps_q;
  end

  // Only an opening write loads the window; any other control write shuts it.
  always_comb
  begin
    if (chip_rst)
      win_d = 3'h0;
    else if (wr_ct && w_ce && w_en)
      win_d = wd_pkg::WINDOW_LOAD;
    else if (wr_ct || !win_open)
      win_d = 3'h0;
    else
      win_d = win_q - 3'h1;
  end

  // A software write wins over the hardware clear at a time-out.
  always_comb
  begin
    if (chip_rst)
      irq_en_d = 1'b0;
    else if (wr_ct)
      irq_en_d = wdata[wd_pkg::CT_IRQ_EN];
    else if (timeout && en_eff)
      irq_en_d = 1'b0;
    else
      irq_en_d = irq_en_q;
  end

  always_comb
  begin
    if (chip_rst)
      irq_flag_d = 1'b0;
    else if (timeout && irq_en_q)
      irq_flag_d = 1'b1;
    else if (irq_taken || (wr_ct && wdata[wd_pkg::CT_IRQ_FLAG]))
      irq_flag_d = 1'b0;
    else
      irq_flag_d = irq_flag_q;
  end

  assign rc_word = {4'h0, wdr_q, bor_q, pin_q, por_q};
  assign ct_word = {irq_flag_q, irq_en_q, ps_q[3], win_open,
                    en_eff, ps_q[2:0]};

  // Read data stand for one cycle only, then fall back to the idle word.
  assign rdata_d = rd_rc ? rc_word :
                   rd_ct ? ct_word :
                   wd_pkg::READ_IDLE;

  assign por_d = next_flag(1'b0, por_q,
                           wr_rc & ~wdata[wd_pkg::RC_POWERON]);
  assign pin_d = next_flag(pin_reset_evt, pin_q,
                           wr_rc & ~wdata[wd_pkg::RC_PIN]);
  assign bor_d = next_flag(brownout_reset_evt, bor_q,
                           wr_rc & ~wdata[wd_pkg::RC_BROWNOUT]);
  assign wdr_d = next_flag(wd_reset_q, wdr_q, flag_clr);

  assign wd_reset_d = timeout & ~irq_en_q & ~chip_rst;
  assign wd_irq_d = irq_flag_q & irq_en_q & global_irq_enable;
  assign bandgap_d = brownout_detect_on | comparator_bandgap_select |
                     adc_enable;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      en_q <= 1'b0;
    else
      en_q <= en_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ps_q <= wd_pkg::PS_RESET;
    else
      ps_q <= ps_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      win_q <= 3'h0;
    else
      win_q <= win_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_en_q <= 1'b0;
    else
      irq_en_q <= irq_en_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_flag_q <= 1'b0;
    else
      irq_flag_q <= irq_flag_d;
  end

  // Reset-cause flags survive the synchronous chip reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      por_q <= wd_pkg::POWERON_FLAG_RESET;
    else
      por_q <= por_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_q <= wd_pkg::OTHER_FLAG_RESET;
    else
      pin_q <= pin_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bor_q <= wd_pkg::OTHER_FLAG_RESET;
    else
      bor_q <= bor_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wdr_q <= wd_pkg::OTHER_FLAG_RESET;
    else
      wdr_q <= wdr_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= wd_pkg::READ_IDLE;
    else
      rdata_q <= rdata_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wd_reset_q <= 1'b0;
    else
      wd_reset_q <= wd_reset_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wd_irq_q <= 1'b0;
    else
      wd_irq_q <= wd_irq_d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bandgap_power_q <= 1'b0;
    else
      bandgap_power_q <= bandgap_d;
  end

endmodule : watchdog_reset_flags
`default_nettype wire

// file: wd_pkg.sv
// Shared constants for the watchdog and reset-cause flag block.
package wd_pkg;
  // Register addresses on the plain register port.
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_WD_CONTROL = 8'h01;
  // Reset-cause register bit positions.
  localparam int unsigned RC_POWERON = 0;
  localparam int unsigned RC_PIN = 1;
  localparam int unsigned RC_BROWNOUT = 2;
  localparam int unsigned RC_WATCHDOG = 3;
  // Watchdog control register bit positions.
  localparam int unsigned CT_IRQ_FLAG = 7;
  localparam int unsigned CT_IRQ_EN = 6;
  localparam int unsigned CT_PS_HI = 5;
  localparam int unsigned CT_CHANGE_EN = 4;
  localparam int unsigned CT_ENABLE = 3;
  localparam int unsigned CT_PS_LO_TOP = 2;
  // Reset values.
  localparam logic POWERON_FLAG_RESET = 1'b1;
  localparam logic OTHER_FLAG_RESET = 1'b0;
  localparam logic [3:0] PS_RESET = 4'h0;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // Prescaler codes.
  localparam logic [3:0] PS_LAST_VALID = 4'h9;
  localparam logic [3:0] PS_FALLBACK = 4'h0;
  // Oscillator rate and shortest period in oscillator cycles.
  localparam int unsigned WD_OSC_KHZ = 128;
  localparam int unsigned BASE_PERIOD = 2048;
  // Change-enable window length in system clock cycles.
  localparam int unsigned CHANGE_WINDOW = 4;
  localparam logic [2:0] WINDOW_LOAD = 3'(CHANGE_WINDOW);
endpackage : wd_pkg

// file: wd_checker_assertions.sv
// Concurrent checks on the ports of the watchdog and reset-cause block.
`timescale 1ns/10ps
`default_nettype none
module wd_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata_q,
  // Core, reset and fuse signals.
  input wire logic wd_restart,
  input wire logic global_irq_enable,
  input wire logic wd_irq_q,
  input wire logic pin_reset_evt,
  input wire logic wd_reset_q,
  input wire logic wd_always_on_fuse,
  // Reference power control.
  input wire logic adc_enable,
  input wire logic bandgap_power_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd_c = rd_en && addr == wd_pkg::ADDR_WD_CONTROL;
  wire rd_f = rd_en && addr == wd_pkg::ADDR_RESET_CAUSE;
  sequence s_open;
    wr_en && addr == wd_pkg::ADDR_WD_CONTROL && wdata[4] && wdata[3];
  endsequence
  sequence s_late;
    s_open ##1 !wr_en [*6] ##0 rd_c;
  endsequence
  a_pulse_single: assert property
    (wd_reset_q |=> !wd_reset_q [*8])
    else $error("watchdog reset pulse too long");
  a_restart_holds: assert property
    (wd_restart |-> ##3 !wd_reset_q [*8])
    else $error("reset right after a restart");
  a_irq_gated: assert property (!global_irq_enable |=> !wd_irq_q)
    else $error("interrupt request without global enable");
  a_bandgap_on: assert property (adc_enable |=> bandgap_power_q)
    else $error("reference off while converter enabled");
  a_pin_flag: assert property
    (pin_reset_evt ##1 rd_f |=> rdata_q[1])
    else $error("pin reset flag not set");
  a_lvl2_enable: assert property
    (wd_always_on_fuse [*5] ##0 rd_c |=> rdata_q[3])
    else $error("enable bit not held in level two");
  a_window_open: assert property (s_open ##2 rd_c |=> rdata_q[4])
    else $error("change enable not open");
  a_window_shut: assert property (s_late |=> !rdata_q[4])
    else $error("change enable not closed");
endmodule : wd_checker
bind watchdog_reset_flags wd_checker u_chk (.clk, .rst_b, .addr, .wdata,
  .wr_en, .rd_en, .rdata_q, .wd_restart, .global_irq_enable, .wd_irq_q,
  .pin_reset_evt, .wd_reset_q, .wd_always_on_fuse, .adc_enable,
  .bandgap_power_q);
`default_nettype wire

// file: watchdog_reset_flags_tb.sv
// Self-checking bench for the watchdog and reset-cause block.
`timescale 1ns/10ps
`default_nettype none
module watchdog_reset_flags_tb;
  localparam logic [7:0] rc_a = wd_pkg::ADDR_RESET_CAUSE;
  localparam logic [7:0] ct_a = wd_pkg::ADDR_WD_CONTROL;
  logic clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, wd_restart = 0;
  logic global_irq_enable = 0, irq_taken = 0, brownout_reset_evt = 0;
  logic pin_reset_evt = 0, wd_osc = 0, wd_always_on_fuse = 0;
  logic brownout_detect_on = 0, comparator_bandgap_select = 0;
  logic adc_enable = 0, wd_irq_q, wd_reset_q, bandgap_power_q;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_q;
  int n_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  always #3906.25 wd_osc = ~wd_osc;
  watchdog_reset_flags #(.BASE_CYCLES(4)) uut (.clk, .rst_b, .addr, .wdata,
    .wr_en, .rd_en, .rdata_q, .wd_restart, .global_irq_enable, .irq_taken,
    .wd_irq_q, .brownout_reset_evt, .pin_reset_evt, .wd_reset_q, .wd_osc,
    .wd_always_on_fuse, .brownout_detect_on, .comparator_bandgap_select,
    .adc_enable, .bandgap_power_q);
  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] seen, e, input string w);
    n_compared++;
    if (seen !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", w, e, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rc(input logic [7:0] a, e, input string w);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata_q, e, w);
    @(posedge clk);
  endtask : rc
  task automatic wt(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim && s !== 1'b1; i++)
      @(negedge clk);
    if (i == lim)
    begin
      n_errors++;
      give_verdict();
    end
    @(posedge clk);
  endtask : wt
  task automatic t_flags();
    rc(rc_a, 8'h01, "cause");
    rc(ct_a, 8'h00, "control");
    wr(8'h05, 8'hFF);
    pin_reset_evt <= 1'b1;
    brownout_reset_evt <= 1'b1;
    @(posedge clk);
    pin_reset_evt <= 1'b0;
    brownout_reset_evt <= 1'b0;
    rc(rc_a, 8'h07, "cause set");
    wr(rc_a, 8'hFA);
    rc(rc_a, 8'h02, "cause clear");
    wr(rc_a, 8'h00);
  endtask : t_flags
  task automatic t_window();
    wr(ct_a, 8'h08);
    wr(ct_a, 8'h00);
    rc(ct_a, 8'h08, "no disable");
    wr(ct_a, 8'h18);
    rc(ct_a, 8'h18, "window open");
    wr(ct_a, 8'h00);
    rc(ct_a, 8'h00, "disabled");
    wr(ct_a, 8'h08);
    wr(ct_a, 8'h18);
    repeat (4) @(posedge clk);
    rc(ct_a, 8'h08, "window shut");
    wr(ct_a, 8'h00);
    rc(ct_a, 8'h08, "late write");
    wr(ct_a, 8'h18);
    wr(ct_a, 8'h00);
  endtask : t_window
  task automatic t_bandgap();
    for (int k = 0; k < 8; k++)
    begin
      {adc_enable, comparator_bandgap_select, brownout_detect_on} <= 3'(k);
      @(posedge clk);
      @(negedge clk);
      chk({7'h00, bandgap_power_q}, {7'h00, k != 0}, "bandgap");
      @(posedge clk);
    end
  endtask : t_bandgap
  task automatic t_expiry();
    wr(ct_a, 8'h2A);
    wt(wd_reset_q, 8000);
    rc(rc_a, 8'h08, "wd flag");
    rc(ct_a, 8'h08, "forced enable");
    wr(rc_a, 8'h00);
    wr(ct_a, 8'h08);
    repeat (8)
    begin
      wd_restart <= 1'b1;
      @(posedge clk);
      wd_restart <= 1'b0;
      repeat (1000) @(posedge clk);
    end
    rc(rc_a, 8'h00, "restarted");
    wr(ct_a, 8'h18);
    wr(ct_a, 8'h00);
  endtask : t_expiry
  task automatic t_irq();
    global_irq_enable <= 1'b1;
    wr(ct_a, 8'h40);
    wt(wd_irq_q, 8000);
    rc(ct_a, 8'hC0, "irq flag");
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, wd_irq_q}, 8'h00, "irq masked");
    irq_taken <= 1'b1;
    @(posedge clk);
    irq_taken <= 1'b0;
    rc(ct_a, 8'h40, "vector clear");
    global_irq_enable <= 1'b1;
    wr(ct_a, 8'h48);
    wt(wd_reset_q, 16000);
    rc(rc_a, 8'h08, "second expiry");
    wr(rc_a, 8'h00);
    wr(ct_a, 8'h18);
    wr(ct_a, 8'h00);
  endtask : t_irq
  task automatic t_level2();
    wd_always_on_fuse <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    rc(rc_a, 8'h01, "power on");
    wr(ct_a, 8'h00);
    rc(ct_a, 8'h08, "always on");
    wr(ct_a, 8'h18);
    wr(ct_a, 8'h03);
    rc(ct_a, 8'h0B, "new period");
    wr(ct_a, 8'h01);
    rc(ct_a, 8'h0B, "guarded period");
  endtask : t_level2
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_flags();
    t_window();
    t_bandgap();
    t_expiry();
    t_irq();
    t_level2();
    give_verdict();
  end
endmodule : watchdog_reset_flags_tb
`default_nettype wire
